/* rtl/sarpp_pkg.sv */
package sarpp_pkg;

    // Result word and byte lane widths.
    localparam int RES_W = 16;
    localparam int BYTE_W = 8;

    // Clock period and conversion time.
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CONV_TIME_NS = 8000;
    localparam int CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;

    // Least convert strobe width and longest one.
    localparam int STROBE_MIN_NS = 40;
    localparam int STROBE_MIN_CYCLES = (STROBE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STROBE_MAX_NS = 7000;
    localparam int STROBE_MAX_CYCLES = (STROBE_MAX_NS * 1000) / CLK_PERIOD_PS;

    // Result buffer geometry.
    localparam int FIFO_DEPTH = 8;

    // Full scale codes in two's complement, and the result reset value.
    localparam logic [15:0] CODE_NEG_FS = 16'h8000;
    localparam logic [15:0] CODE_POS_FS = 16'h7FFF;
    localparam logic [15:0] RESULT_RST = 16'h0000;

    typedef enum logic [1:0] {
        SARPP_IDLE,
        SARPP_CONV,
        SARPP_DONE
    } sarpp_state_t;

    // Pin bundle of the result bus.
    typedef struct packed {
        logic [RES_W-1:0] data;
        logic [RES_W-1:0] oe;
    } sarpp_bus_t;

endpackage : sarpp_pkg

/* rtl/sarpp_fifo.sv */
`timescale 1ns/1ps
module sarpp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clock, // System clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic in_valid, // Write request.
    output logic in_ready, // Space available.
    input wire logic [WIDTH-1:0] in_data, // Write word.
    output logic out_valid, // Word available.
    input wire logic out_ready, // Read accept.
    output logic [WIDTH-1:0] out_data // Head word.
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    chk_fifo_no_over: assert property (@(posedge clock) disable iff (!rst_b)
        cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule : sarpp_fifo

/* rtl/sarpp_port.sv */
`timescale 1ns/1ps
// Behaviour
// - Result lines float unless selected and reading.
// - Line 15 carries MSB, line 0 LSB.
// - Byte select low gives high byte.
// - Read/convert falling with select starts conversion.
// - Read/convert rising with select enables outputs.
// - Select and read/convert ORed; select fall converts.
// - Busy low from start until result updated.
// - Convert commands ignored while busy low.
// - Results are two's complement 8000 to 7FFF.
module sarpp_port #(
    parameter int RES_W = sarpp_pkg::RES_W,
    parameter int CONV_CYCLES = sarpp_pkg::CONV_CYCLES,
    parameter int DEPTH = sarpp_pkg::FIFO_DEPTH
) (
    input wire logic clock, // System clock, 200 MHz.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic select_b, // Chip select pin, active low.
    input wire logic read_conv, // Read high, convert low.
    input wire logic byte_sel, // Byte lane select pin.
    input wire logic [RES_W-1:0] sample_data, // Digitised sample from the core.
    input wire logic sample_valid, // Core sample strobe.
    output logic sample_ready, // Buffer can take a sample.
    output logic start_hold, // Pulse that freezes the sampler.
    output logic busy_b, // Busy flag, active low.
    output logic [RES_W-1:0] result_o, // Result lines, output value.
    output logic [RES_W-1:0] result_oe, // Result lines, output enable.
    output logic [sarpp_pkg::BYTE_W-1:0] byte_o, // Byte lanes, output value.
    output logic byte_oe // Byte lanes, output enable.
);
    localparam int CW = $clog2(CONV_CYCLES + 1);
    localparam int BW = sarpp_pkg::BYTE_W;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic sel_m_q;
    logic sel_s_q;
    logic rc_m_q;
    logic rc_s_q;
    logic byte_m_q;
    logic byte_s_q;

    // Each pin passes two flops, reset to its idle level, before logic reads it.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sel_m_q <= 1'b1;
            sel_s_q <= 1'b1;
        end else begin
            sel_m_q <= select_b;
            sel_s_q <= sel_m_q;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rc_m_q <= 1'b1;
            rc_s_q <= 1'b1;
        end else begin
            rc_m_q <= read_conv;
            rc_s_q <= rc_m_q;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            byte_m_q <= 1'b0;
            byte_s_q <= 1'b0;
        end else begin
            byte_m_q <= byte_sel;
            byte_s_q <= byte_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command decode.

    logic cmd_low;
    logic cmd_low_q;
    logic conv_cmd;
    logic read_en;

    assign cmd_low = !(sel_s_q || rc_s_q);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmd_low_q <= 1'b0;
        end else begin
            cmd_low_q <= cmd_low;
        end
    end

    assign conv_cmd = cmd_low && !cmd_low_q;

    // Read enable when selected and high.
    assign read_en = !sel_s_q && rc_s_q;

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer.

    sarpp_pkg::sarpp_state_t state_q;
    logic [CW-1:0] cnt_q;
    logic [RES_W-1:0] result_q;
    logic fifo_valid;
    logic fifo_pop;
    logic [RES_W-1:0] fifo_data;
    logic conv_last;

    assign conv_last = (cnt_q == CW'(CONV_CYCLES - 1));

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= sarpp_pkg::SARPP_IDLE;
        end else begin
            unique case (state_q)
                sarpp_pkg::SARPP_IDLE: begin
                    if (conv_cmd) begin
                        state_q <= sarpp_pkg::SARPP_CONV;
                    end
                end
                sarpp_pkg::SARPP_CONV: begin
                    // Busy stays low past the conversion time while the buffer is empty.
                    if (conv_last && fifo_valid) begin
                        state_q <= sarpp_pkg::SARPP_DONE;
                    end
                end
                sarpp_pkg::SARPP_DONE: begin
                    state_q <= sarpp_pkg::SARPP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else if (state_q != sarpp_pkg::SARPP_CONV) begin
            cnt_q <= '0;
        end else if (!conv_last) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign start_hold = (state_q == sarpp_pkg::SARPP_IDLE) && conv_cmd;
    assign fifo_pop = (state_q == sarpp_pkg::SARPP_CONV) && conv_last;

    // Result register updated before busy rises.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            result_q <= sarpp_pkg::RESULT_RST;
        end else if (fifo_pop && fifo_valid) begin
            result_q <= fifo_data;
        end
    end

    assign busy_b = (state_q == sarpp_pkg::SARPP_IDLE);

    sarpp_fifo #(
        .WIDTH(RES_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_b(rst_b),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data(sample_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output drivers.

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            result_o <= '0;
        end else begin
            // Bit order kept MSB at 15.
            result_o <= result_q;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            result_oe <= '0;
        end else begin
            result_oe <= {RES_W{read_en}};
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            byte_o <= '0;
        end else begin
            byte_o <= byte_s_q ? result_q[BW-1:0] : result_q[RES_W-1:RES_W-BW];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            byte_oe <= 1'b0;
        end else begin
            byte_oe <= read_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_start;
        busy_b && conv_cmd;
    endsequence

    sequence s_conv_wait;
        (state_q == sarpp_pkg::SARPP_CONV) && conv_last && !fifo_valid;
    endsequence

    sequence s_mid_cmd;
        (state_q == sarpp_pkg::SARPP_CONV) && !conv_last && conv_cmd;
    endsequence

    chk_start_busy_low: assert property (@(posedge clock) disable iff (!rst_b)
        s_start |=> !busy_b) else $error("busy did not fall on convert");

    chk_busy_hold: assert property (@(posedge clock) disable iff (!rst_b)
        s_start |=> !busy_b [*8]) else $error("busy rose too early");

    chk_float_desel: assert property (@(posedge clock) disable iff (!rst_b)
        sel_s_q |=> result_oe == '0 && !byte_oe) else $error("bus driven while deselected");

    // Outputs float while convert is low.
    chk_float_conv: assert property (@(posedge clock) disable iff (!rst_b)
        !rc_s_q |=> result_oe == '0 && !byte_oe) else $error("bus driven while converting");

    chk_read_drive: assert property (@(posedge clock) disable iff (!rst_b)
        read_en |=> result_oe == '1 && byte_oe) else $error("bus not driven on read");

    // High byte when byte select low.
    chk_byte_high: assert property (@(posedge clock) disable iff (!rst_b)
        !byte_s_q |=> byte_o == $past(result_q[RES_W-1:RES_W-BW]))
        else $error("wrong byte lane");

    // Low byte when byte select high.
    chk_byte_low: assert property (@(posedge clock) disable iff (!rst_b)
        byte_s_q |=> byte_o == $past(result_q[BW-1:0])) else $error("wrong low byte lane");

    chk_word_order: assert property (@(posedge clock) disable iff (!rst_b)
        1'b1 |=> result_o == $past(result_q)) else $error("result word misordered");

    chk_busy_rise: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(busy_b) |-> $past(state_q) == sarpp_pkg::SARPP_DONE)
        else $error("busy rose without update");

    // Busy held while no word is ready.
    chk_busy_wait: assert property (@(posedge clock) disable iff (!rst_b)
        s_conv_wait |=> !busy_b) else $error("busy rose without a result");

    chk_result_load: assert property (@(posedge clock) disable iff (!rst_b)
        fifo_pop && fifo_valid |=> result_q == $past(fifo_data))
        else $error("result not loaded");

    chk_done_idle: assert property (@(posedge clock) disable iff (!rst_b)
        state_q == sarpp_pkg::SARPP_DONE |=> busy_b) else $error("busy stuck after done");

    // A command mid conversion changes nothing.
    chk_cmd_ignored: assert property (@(posedge clock) disable iff (!rst_b)
        s_mid_cmd |=> cnt_q == $past(cnt_q) + 1'b1 && !busy_b)
        else $error("command during conversion took effect");

    chk_sel_fall: assert property (@(posedge clock) disable iff (!rst_b)
        busy_b && !rc_s_q && $fell(sel_s_q) |-> start_hold) else $error("select fall ignored");

    logic [CW-1:0] busy_len_q;

    // Counts busy cycles for the length check; it saturates at the top.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            busy_len_q <= '0;
        end else if (busy_b) begin
            busy_len_q <= '0;
        end else if (busy_len_q != '1) begin
            busy_len_q <= busy_len_q + 1'b1;
        end
    end

    // Busy low for the whole conversion.
    chk_busy_len: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(busy_b) |-> busy_len_q >= CW'(CONV_CYCLES))
        else $error("busy pulse too short");

endmodule : sarpp_port

/* verif/sarpp_host.sv */
`timescale 1ns/1ps
module sarpp_host (
    input wire logic clock, // System clock.
    input wire logic busy_b, // Busy flag, active low.
    output logic select_b, // Chip select, active low.
    output logic read_conv, // Read high, convert low.
    output logic byte_sel, // Byte lane select.
    output logic timed_out // Busy did not return high.
);
    initial begin
        select_b = 1'b1;
        read_conv = 1'b1;
        byte_sel = 1'b0;
        timed_out = 1'b0;
    end
    task automatic strobe(input bit rc_first);
        if (rc_first) begin
            read_conv = 1'b0;
            @(negedge clock);
        end
        select_b = 1'b0;
        read_conv = 1'b0;
        repeat (10) @(negedge clock);
        read_conv = 1'b1;
    endtask : strobe
    // release before busy rises, read after it rises.
    task automatic convert(input bit rc_first, input bit again);
        @(negedge clock);
        strobe(rc_first);
        if (again) begin
            repeat (4) @(negedge clock);
            strobe(1'b0);
        end
    endtask : convert
    task automatic wait_ready();
        int n;
        n = 0;
        while (busy_b !== 1'b1 && n < 300) begin
            @(negedge clock);
            n++;
        end
        if (n >= 300) timed_out = 1'b1;
        repeat (6) @(negedge clock);
    endtask : wait_ready
endmodule : sarpp_host

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [15:0] smp;
        logic [7:0] hi;
        logic [7:0] lo;
    } sarpp_row_t;
    localparam sarpp_row_t ROWS [6] = '{
        '{16'h8000, 8'h80, 8'h00}, '{16'h7FFF, 8'h7F, 8'hFF}, '{16'h0000, 8'h00, 8'h00},
        '{16'hFFFF, 8'hFF, 8'hFF}, '{16'h1234, 8'h12, 8'h34}, '{16'hA55A, 8'hA5, 8'h5A}};
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] sample_data = 16'h0000;
    logic sample_valid = 1'b0;
    logic sample_ready, start_hold, busy_b, byte_oe, select_b, read_conv, byte_sel, timed_out;
    logic [15:0] result_o, result_oe;
    logic [7:0] byte_o;
    int num_errors = 0;
    int cmp_count = 0;
    int starts = 0;
    always #2.5 clock = ~clock;
    always @(posedge clock) if (start_hold === 1'b1) starts++;
    sarpp_port #(.CONV_CYCLES(40)) u_dut (.clock(clock), .rst_b(rst_b), .select_b(select_b),
        .read_conv(read_conv), .byte_sel(byte_sel), .sample_data(sample_data),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .start_hold(start_hold),
        .busy_b(busy_b), .result_o(result_o), .result_oe(result_oe), .byte_o(byte_o),
        .byte_oe(byte_oe));
    sarpp_host u_host (.clock(clock), .busy_b(busy_b), .select_b(select_b),
        .read_conv(read_conv), .byte_sel(byte_sel), .timed_out(timed_out));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask : check
    task automatic give_verdict();
        $display("errors %0d, comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task automatic push(input logic [15:0] v);
        @(negedge clock);
        sample_data = v;
        sample_valid = 1'b1;
        do @(posedge clock); while (sample_ready !== 1'b1);
        @(negedge clock);
        sample_valid = 1'b0;
    endtask : push
    task automatic run_conv(input sarpp_row_t r, input bit rc_first, input bit again);
        int s0;
        s0 = starts;
        u_host.convert(rc_first, again);
        check({15'h0000, busy_b}, 16'h0000);
        u_host.wait_ready();
        check(starts - s0, 16'h0001);
        check({15'h0000, timed_out}, 16'h0000);
        check(result_oe, 16'hFFFF);
        check(result_o, r.smp);
        check({7'h00, byte_oe, byte_o}, {8'h01, r.hi});
        u_host.byte_sel = 1'b1;
        repeat (6) @(negedge clock);
        check({7'h00, byte_oe, byte_o}, {8'h01, r.lo});
        u_host.byte_sel = 1'b0;
        u_host.select_b = 1'b1;
        repeat (6) @(negedge clock);
        check({result_oe[15:1], byte_oe}, 16'h0000);
    endtask : run_conv
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (12) @(negedge clock);
        rst_b = 1'b1;
        check({result_oe[15:1], byte_oe}, 16'h0000);
        check({15'h0000, busy_b}, 16'h0001);
        repeat (4) @(negedge clock);
        for (int i = 0; i < 6; i++) begin
            push(ROWS[i].smp);
            run_conv(ROWS[i], 1'b0, 1'b0);
        end
        push(ROWS[4].smp);
        run_conv(ROWS[4], 1'b1, 1'b0);
        push(ROWS[5].smp);
        push(ROWS[0].smp);
        run_conv(ROWS[5], 1'b0, 1'b1);
        run_conv(ROWS[0], 1'b0, 1'b0);
        for (int i = 0; i < 8; i++) push(ROWS[i % 6].smp);
        @(negedge clock);
        check({15'h0000, sample_ready}, 16'h0000);
        for (int i = 0; i < 8; i++) run_conv(ROWS[i % 6], 1'b0, 1'b0);
        u_host.convert(1'b0, 1'b0);
        repeat (50) @(negedge clock);
        check({15'h0000, busy_b}, 16'h0000);
        push(ROWS[4].smp);
        u_host.wait_ready();
        check({15'h0000, timed_out}, 16'h0000);
        check(result_o, ROWS[4].smp);
        give_verdict();
    end
endmodule : testbench
